// >>> logic/strap_and_test_mode_capture.sv
// Function
// - Capture each strap on power good rising edge; pins then resume normal use.
// - Safe strap high drives safe code on speed strap outputs during bus reset.
// - Safe strap level reads in bit 2 of register D4h.
// - Grant A strap low inverts A16 on every firmware range cycle.
// - Boot block swap strap state reads in bit 13 of register D4h.
// - Software cannot clear swap bit while grant A strap was captured low.
// - Speaker strap high disables hang timer reboot.
// - Reboot inhibit strap reads in bit 1 of register D4h.
// - Hub compensation strap low selects series 1.0, high parallel 1.5 buffers.
// - Test modes decode after power good high 76 clocks, counting reset low clocks.
// - Count below 4 none, 4 to 7 XOR chains, 8 tri-state, above 42 none.
// - Weak pull-up on grant A during capture keeps swap off by default.
// - RTC well reset clears RTC well bits and sets power loss status.
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module strap_and_test_mode_capture
   import strap_pkg::*;
(
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output      logic [31:0]       prdata,
   output      logic              pready,
   output      logic              pslverr,
   input  wire logic              power_good_input,
   input  wire logic              rtc_well_reset_n,
   input  wire logic              bus_reset,
   input  wire logic              codec_serial_out,
   input  wire logic              pcpci_grant_a_n,
   input  wire logic              speaker_output,
   input  wire logic              hub_compensation_pin,
   input  wire logic              deeper_sleep_regulator_pin,
   input  wire logic              fw_cycle,
   input  wire logic              fw_addr_a16,
   output      logic              fw_addr_a16_out,
   output      logic [FREQ_W-1:0] cpu_speed_strap,
   output      logic              grant_a_pullup_en,
   output      logic              hang_timer_reboot_en,
   output      logic              hub_buffer_parallel,
   output      logic [2:0]        test_mode
);
   // ----------------------------------------------------------------
   // Internal state
   // ----------------------------------------------------------------
   logic                     pg_q;
   logic                     capture;
   logic [STRAP_W-1:0]       strap_q;
   logic                     swap_q;
   logic [FREQ_W-1:0]        freq_q;
   logic                     rtc_loss_q;
   logic [RTC_SCRATCH_W-1:0] scratch_q;
   logic                     access;
   logic                     wr_en;
   logic                     hit_strap;
   logic                     hit_rtc;
   logic [31:0]              rd_d;

   assign capture   = power_good_input & ~pg_q;
   assign access    = psel & penable & pready;
   assign wr_en     = access & pwrite;
   assign hit_strap = (paddr == STRAP_STATUS_CONTROL_OFF);
   assign hit_rtc   = (paddr == RTC_WELL_STATUS_OFF);

   // ----------------------------------------------------------------
   // Strap capture
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pg_q <= 1'b0;
      end else begin
         pg_q <= power_good_input;
      end
   end

   strap_latch u_strap_latch (
      .pclk      (pclk),
      .presetn   (presetn),
      .capture   (capture),
      .pins      ({deeper_sleep_regulator_pin, hub_compensation_pin, speaker_output,
                   pcpci_grant_a_n, codec_serial_out}),
      .latched_q (strap_q)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         grant_a_pullup_en <= 1'b1;
      end else if (!power_good_input) begin
         grant_a_pullup_en <= 1'b1;
      end else begin
         grant_a_pullup_en <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Boot block swap
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         swap_q <= 1'b0;
      end else if (capture) begin
         swap_q <= ~pcpci_grant_a_n;
      end else if (wr_en && hit_strap) begin
         swap_q <= pwdata[BOOT_SWAP_BIT] | ~strap_q[S_GNT_A];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fw_addr_a16_out <= 1'b0;
      end else begin
         fw_addr_a16_out <= fw_addr_a16 ^ (fw_cycle & swap_q);
      end
   end

   // ----------------------------------------------------------------
   // Processor speed straps, hang timer, hub buffers
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         freq_q <= FREQ_RESET;
      end else if (wr_en && hit_strap) begin
         freq_q <= pwdata[FREQ_LSB +: FREQ_W];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_speed_strap <= '0;
      end else if (!bus_reset) begin
         cpu_speed_strap <= '0;
      end else if (strap_q[S_SAFE]) begin
         cpu_speed_strap <= SAFE_SPEED_CODE;
      end else begin
         cpu_speed_strap <= freq_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hang_timer_reboot_en <= 1'b1;
         hub_buffer_parallel  <= 1'b0;
      end else begin
         hang_timer_reboot_en <= ~strap_q[S_SPEAKER_OUTPUT];
         hub_buffer_parallel  <= strap_q[S_HUB_COMP];
      end
   end

   // ----------------------------------------------------------------
   // RTC well bits
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rtc_loss_q <= 1'b0;
      end else if (!rtc_well_reset_n) begin
         rtc_loss_q <= 1'b1;
      end else if (wr_en && hit_rtc && pwdata[RTC_PWR_LOSS_BIT]) begin
         rtc_loss_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch_q <= SCRATCH_RESET;
      end else if (!rtc_well_reset_n) begin
         scratch_q <= SCRATCH_RESET;
      end else if (wr_en && hit_rtc) begin
         scratch_q <= pwdata[RTC_SCRATCH_LSB +: RTC_SCRATCH_W];
      end
   end

   // ----------------------------------------------------------------
   // Test mode selection
   // ----------------------------------------------------------------
   test_mode_decoder u_test_mode_decoder (
      .pclk             (pclk),
      .presetn          (presetn),
      .power_good       (power_good_input),
      .rtc_well_reset_n (rtc_well_reset_n),
      .test_mode_q      (test_mode)
   );

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      if (hit_strap) begin
         rd_d[REBOOT_INHIBIT_BIT]         = strap_q[S_SPEAKER_OUTPUT];
         rd_d[SAFE_SPEED_BIT]             = strap_q[S_SAFE];
         rd_d[HUB_COMP_BIT]               = strap_q[S_HUB_COMP];
         rd_d[DEEPER_SLEEP_BIT]           = strap_q[S_DEEP_SLEEP];
         rd_d[FREQ_LSB +: FREQ_W]         = freq_q;
         rd_d[BOOT_SWAP_BIT]              = swap_q;
      end else if (hit_rtc) begin
         rd_d[RTC_PWR_LOSS_BIT]           = rtc_loss_q;
         rd_d[RTC_SCRATCH_LSB +: RTC_SCRATCH_W] = scratch_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= ~(hit_strap | hit_rtc);
         prdata  <= pwrite ? 32'h0000_0000 : rd_d;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   swap_sticky_a: assert property (!strap_q[S_GNT_A] && !capture |=> swap_q)
      else $error("Boot block swap bit cleared while strap low.");
   a16_invert_a: assert property (fw_cycle |=> fw_addr_a16_out == ($past(fw_addr_a16) ^ $past(swap_q)))
      else $error("A16 not inverted on firmware cycle.");
   safe_speed_a: assert property (bus_reset && strap_q[S_SAFE] |=> cpu_speed_strap == SAFE_SPEED_CODE)
      else $error("Safe speed code not driven during reset.");
   pullup_cap_a: assert property (capture |-> grant_a_pullup_en)
      else $error("Pull-up off at strap capture.");
   rtc_loss_a: assert property (!rtc_well_reset_n |=> rtc_loss_q && scratch_q == SCRATCH_RESET)
      else $error("RTC well reset did not act.");
   reboot_inh_a: assert property (strap_q[S_SPEAKER_OUTPUT] |=> !hang_timer_reboot_en)
      else $error("Hang timer reboot not disabled.");
   hub_mode_a: assert property (##1 hub_buffer_parallel == $past(strap_q[S_HUB_COMP]))
      else $error("Hub buffer mode differs from strap.");
   status_read_a: assert property (psel && penable && !pready && !pwrite && hit_strap
                                   |=> prdata[BOOT_SWAP_BIT] == $past(swap_q)
                                       && prdata[SAFE_SPEED_BIT] == $past(strap_q[S_SAFE])
                                       && prdata[REBOOT_INHIBIT_BIT] == $past(strap_q[S_SPEAKER_OUTPUT]))
      else $error("Strap status read mismatch.");
endmodule : strap_and_test_mode_capture

// >>> logic/strap_latch.sv
`timescale 1ns/10ps
module strap_latch
   import strap_pkg::*;
(
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic               capture,
   input  wire logic [STRAP_W-1:0] pins,
   output      logic [STRAP_W-1:0] latched_q
);
   // ----------------------------------------------------------------
   // Per-strap capture flops.
   // ----------------------------------------------------------------
   for (genvar i = 0; i < STRAP_W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            latched_q[i] <= STRAP_RESET[i];
         end else if (capture) begin
            latched_q[i] <= pins[i];
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   capture_value_a: assert property (capture |=> latched_q == $past(pins))
      else $error("Strap not captured at power good edge.");
   hold_value_a: assert property (!capture |=> $stable(latched_q))
      else $error("Strap changed without a capture.");
endmodule : strap_latch

// >>> logic/test_mode_decoder.sv
`timescale 1ns/10ps
module test_mode_decoder
   import strap_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       power_good,
   input  wire logic       rtc_well_reset_n,
   output      logic [2:0] test_mode_q
);
   tm_state_t        state_q;
   logic [CNT_W-1:0] pg_cnt_q;
   logic [CNT_W-1:0] low_cnt_q;

   // ----------------------------------------------------------------
   // Power good qualification and low-pulse counting.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= WAIT_PG;
         pg_cnt_q  <= '0;
         low_cnt_q <= '0;
      end else if (!power_good) begin
         state_q   <= WAIT_PG;
         pg_cnt_q  <= '0;
         low_cnt_q <= '0;
      end else begin
         unique case (state_q)
            WAIT_PG: begin
               pg_cnt_q <= pg_cnt_q + 7'h01;
               if (pg_cnt_q + 7'h01 >= PG_STABLE_CNT) begin
                  state_q <= ARMED;
               end
            end
            ARMED: begin
               if (!rtc_well_reset_n) begin
                  state_q   <= COUNT;
                  low_cnt_q <= 7'h01;
               end
            end
            COUNT: begin
               if (rtc_well_reset_n) begin
                  state_q <= ARMED;
               end else if (low_cnt_q != CNT_SAT) begin
                  low_cnt_q <= low_cnt_q + 7'h01;
               end
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Decode the count when the low pulse ends.
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_mode_q <= TM_NONE;
      end else if (!power_good) begin
         test_mode_q <= TM_NONE;
      end else if (state_q == COUNT && rtc_well_reset_n) begin
         if (low_cnt_q < CNT_XOR1 || low_cnt_q > CNT_ALL_Z) begin
            test_mode_q <= TM_NONE;
         end else begin
            test_mode_q <= TM_XOR1 + 3'(low_cnt_q - CNT_XOR1);
         end
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   early_pg_a: assert property (state_q == WAIT_PG |-> test_mode_q == TM_NONE)
      else $error("Test mode selected before power good settled.");
   allz_map_a: assert property (state_q == COUNT && rtc_well_reset_n && power_good
                                && low_cnt_q == CNT_ALL_Z |=> test_mode_q == TM_ALL_Z)
      else $error("Eight clock pulse did not select tri-state mode.");
   long_none_a: assert property (state_q == COUNT && rtc_well_reset_n && power_good
                                 && low_cnt_q > CNT_RSV_MAX |=> test_mode_q == TM_NONE)
      else $error("Long pulse selected a test mode.");
   short_none_a: assert property (state_q == COUNT && rtc_well_reset_n && power_good
                                  && low_cnt_q < CNT_XOR1 |=> test_mode_q == TM_NONE)
      else $error("Short pulse selected a test mode.");
endmodule : test_mode_decoder

// >>> pkg/strap_pkg.sv
package strap_pkg;
   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] STRAP_STATUS_CONTROL_OFF = 8'hD4;
   localparam logic [7:0] RTC_WELL_STATUS_OFF      = 8'hD8;
   localparam int REBOOT_INHIBIT_BIT = 1;
   localparam int SAFE_SPEED_BIT     = 2;
   localparam int HUB_COMP_BIT       = 4;
   localparam int DEEPER_SLEEP_BIT   = 5;
   localparam int FREQ_LSB           = 8;
   localparam int FREQ_W             = 4;
   localparam int BOOT_SWAP_BIT      = 13;
   localparam int RTC_PWR_LOSS_BIT   = 2;
   localparam int RTC_SCRATCH_LSB    = 8;
   localparam int RTC_SCRATCH_W      = 8;
   localparam logic [FREQ_W-1:0] FREQ_RESET        = 4'h0;
   localparam logic [FREQ_W-1:0] SAFE_SPEED_CODE   = 4'hF;
   localparam logic [RTC_SCRATCH_W-1:0] SCRATCH_RESET = 8'h00;
   // ----------------------------------------------------------------
   // Strap vector layout and pull defaults
   // ----------------------------------------------------------------
   localparam int STRAP_W      = 5;
   localparam int S_SAFE       = 0;
   localparam int S_GNT_A      = 1;
   localparam int S_SPEAKER_OUTPUT       = 2;
   localparam int S_HUB_COMP   = 3;
   localparam int S_DEEP_SLEEP = 4;
   localparam logic [STRAP_W-1:0] STRAP_RESET = 5'h02;
   // ----------------------------------------------------------------
   // Test mode selection
   // ----------------------------------------------------------------
   localparam int PG_STABLE_CLKS = 76;
   localparam int CNT_W          = 7;
   localparam logic [CNT_W-1:0] PG_STABLE_CNT = 7'h4C;
   localparam logic [CNT_W-1:0] CNT_XOR1      = 7'h04;
   localparam logic [CNT_W-1:0] CNT_ALL_Z     = 7'h08;
   localparam logic [CNT_W-1:0] CNT_RSV_MAX   = 7'h2A;
   localparam logic [CNT_W-1:0] CNT_SAT       = 7'h7F;
   localparam logic [2:0] TM_NONE  = 3'h0;
   localparam logic [2:0] TM_XOR1  = 3'h1;
   localparam logic [2:0] TM_ALL_Z = 3'h5;
   typedef enum logic [2:0] {
      WAIT_PG = 3'b001,
      ARMED   = 3'b010,
      COUNT   = 3'b100
   } tm_state_t;
endpackage : strap_pkg

// >>> tb/strap_board_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Board straps and test equipment
// ----------------------------------------------------------------
module strap_board_model
   import strap_pkg::*;
(
   input  wire logic pclk,
   input  wire logic bus_reset,
   input  wire logic grant_a_pullup_en,
   output      logic power_good_input,
   output      logic rtc_well_reset_n,
   output      logic codec_serial_out,
   output      logic pcpci_grant_a_n,
   output      logic speaker_output,
   output      logic hub_compensation_pin,
   output      logic deeper_sleep_regulator_pin
);
   logic               holding;
   logic [STRAP_W-1:0] level;
   logic [4:0]         noise;

   initial begin
      holding = 1'b1;
      level = STRAP_RESET;
      power_good_input = 1'b0;
      rtc_well_reset_n = 1'b1;
      codec_serial_out = 1'b0;
      pcpci_grant_a_n = 1'b1;
      speaker_output = 1'b0;
      hub_compensation_pin = 1'b0;
      deeper_sleep_regulator_pin = 1'b0;
   end

   // Pins show the strap levels while held, then carry random traffic drawn anew every cycle.
   always @(posedge pclk) begin
      noise = 5'($urandom);
      codec_serial_out           <= holding ? level[S_SAFE] : noise[0];
      speaker_output             <= holding ? level[S_SPEAKER_OUTPUT] : noise[2];
      hub_compensation_pin       <= holding ? level[S_HUB_COMP] : noise[3];
      deeper_sleep_regulator_pin <= holding ? level[S_DEEP_SLEEP] : noise[4];
      if (holding && !level[S_GNT_A]) begin
         pcpci_grant_a_n <= 1'b0;
      end else begin
         pcpci_grant_a_n <= grant_a_pullup_en ? 1'b1 : noise[1];
      end
   end

   // Straps are held six clocks before power good rises, then released.
   task automatic power_up(input logic [STRAP_W-1:0] s);
      power_good_input <= 1'b0;
      level <= s;
      holding <= 1'b1;
      repeat (6) @(posedge pclk);
      power_good_input <= 1'b1;
      @(posedge pclk);
      holding <= 1'b0;
      repeat (2) @(posedge pclk);
   endtask : power_up

   // The reset pin is driven low for n clocks once bus reset is released; for n from 9 to 42 it is not driven at all.
   task automatic pulse(input int n);
      for (int k = 0; k < 64 && bus_reset; k++) @(posedge pclk);
      if (n >= 9 && n <= 42) return;
      rtc_well_reset_n <= 1'b0;
      repeat (n) @(posedge pclk);
      rtc_well_reset_n <= 1'b1;
   endtask : pulse
endmodule : strap_board_model

// >>> tb/tb_strap_and_test_mode_capture.sv
`timescale 1ns/10ps
module tb_strap_and_test_mode_capture
   import strap_pkg::*;
;
   typedef struct {logic rd; logic [31:0] d; logic e;} note_t;
   logic               pclk, presetn, psel, penable, pwrite, bus_reset, fw_cycle, fw_addr_a16, swap;
   logic [7:0]         paddr;
   logic [31:0]        pwdata, prdata, w;
   logic               pready, pslverr, fw_addr_a16_out, grant_a_pullup_en, hang_timer_reboot_en;
   logic               hub_buffer_parallel, power_good_input, rtc_well_reset_n, codec_serial_out;
   logic               pcpci_grant_a_n, speaker_output, hub_compensation_pin, deeper_sleep_regulator_pin;
   logic [FREQ_W-1:0]  cpu_speed_strap, freq;
   logic [2:0]         test_mode, tm;
   logic [STRAP_W-1:0] st;
   note_t              notes[$];
   note_t              got;
   int                 miscompares, checks_done;
   int                 counts [8] = '{3, 4, 5, 6, 7, 9, 8, 43};

   strap_and_test_mode_capture strap_and_test_mode_capture_i (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .power_good_input, .rtc_well_reset_n, .bus_reset, .codec_serial_out, .pcpci_grant_a_n,
      .speaker_output, .hub_compensation_pin, .deeper_sleep_regulator_pin, .fw_cycle, .fw_addr_a16,
      .fw_addr_a16_out, .cpu_speed_strap, .grant_a_pullup_en, .hang_timer_reboot_en,
      .hub_buffer_parallel, .test_mode);

   strap_board_model strap_board_model_i (
      .pclk, .bus_reset, .grant_a_pullup_en, .power_good_input, .rtc_well_reset_n, .codec_serial_out,
      .pcpci_grant_a_n, .speaker_output, .hub_compensation_pin, .deeper_sleep_regulator_pin);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   task automatic summarize();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wait_clk(input int n);
      repeat (n) @(posedge pclk);
   endtask : wait_clk

   // One APB transfer; the expected answer is queued for the monitor.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp,
                      input logic err);
      note_t n;
      n.rd = !wr;
      n.d = exp;
      n.e = err;
      notes.push_back(n);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int k = 0; k < 20; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
         if (k == 19) begin
            miscompares++;
            summarize();
         end
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   function automatic logic [31:0] expect_d4();
      logic [31:0] v;
      v = 32'h0;
      v[REBOOT_INHIBIT_BIT] = st[S_SPEAKER_OUTPUT];
      v[SAFE_SPEED_BIT] = st[S_SAFE];
      v[HUB_COMP_BIT] = st[S_HUB_COMP];
      v[DEEPER_SLEEP_BIT] = st[S_DEEP_SLEEP];
      v[FREQ_LSB +: FREQ_W] = freq;
      v[BOOT_SWAP_BIT] = swap;
      return v;
   endfunction : expect_d4

   always @(posedge pclk) begin
      if (presetn === 1'b1 && pready === 1'b1) begin
         got = notes.pop_front();
         check("pslverr", {31'h0, pslverr}, {31'h0, got.e});
         if (got.rd) check("prdata", prdata, got.d);
      end
   end

   initial begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, fw_cycle, fw_addr_a16, swap} = 7'h00;
      bus_reset = 1'b1;
      paddr = 8'h00;
      pwdata = 32'h0;
      freq = 4'h0;
      tm = TM_NONE;
      st = STRAP_RESET;
      miscompares = 0;
      checks_done = 0;
      void'($urandom(32'hEB16FFFE));
      wait_clk(3);
      presetn <= 1'b1;
      wait_clk(1);
      apb(1'b0, STRAP_STATUS_CONTROL_OFF, 32'h0, expect_d4(), 1'b0);
      #1;
      check("pullup", grant_a_pullup_en, 1'b1);
      check("reboot", hang_timer_reboot_en, 1'b1);
      check("test_mode", test_mode, TM_NONE);
      $display("test reset_values done");
      wait_clk(1);
      for (int i = 0; i < 6; i++) begin
         st = STRAP_W'($urandom);
         if (i < 4) begin
            st[S_HUB_COMP] = 1'b0;
            st[S_DEEP_SLEEP] = 1'b0;
         end
         if (i == 0) st[S_GNT_A] = 1'b0;
         bus_reset <= 1'b1;
         strap_board_model_i.power_up(st);
         swap = !st[S_GNT_A];
         #1;
         check("pullup", grant_a_pullup_en, 1'b0);
         check("speed", cpu_speed_strap, st[S_SAFE] ? SAFE_SPEED_CODE : freq);
         check("reboot", hang_timer_reboot_en, !st[S_SPEAKER_OUTPUT]);
         check("hub", hub_buffer_parallel, st[S_HUB_COMP]);
         wait_clk(1);
         bus_reset <= 1'b0;
         wait_clk(2);
         #1;
         check("speed", cpu_speed_strap, 4'h0);
         wait_clk(1);
         apb(1'b0, STRAP_STATUS_CONTROL_OFF, 32'h0, expect_d4(), 1'b0);
         w = $urandom;
         if (!st[S_GNT_A]) w[BOOT_SWAP_BIT] = 1'b0;
         apb(1'b1, STRAP_STATUS_CONTROL_OFF, w, 32'h0, 1'b0);
         freq = w[FREQ_LSB +: FREQ_W];
         if (st[S_GNT_A]) swap = w[BOOT_SWAP_BIT];
         apb(1'b0, STRAP_STATUS_CONTROL_OFF, 32'h0, expect_d4(), 1'b0);
         for (int j = 0; j < 2; j++) begin
            fw_cycle <= j[0];
            fw_addr_a16 <= w[j];
            wait_clk(2);
            #1;
            check("a16", fw_addr_a16_out, w[j] ^ (j[0] & swap));
            wait_clk(1);
         end
         $display("test power_up %0d done", i);
      end
      st = STRAP_RESET;
      bus_reset <= 1'b1;
      strap_board_model_i.power_up(st);
      bus_reset <= 1'b0;
      apb(1'b1, RTC_WELL_STATUS_OFF, 32'h0000A504, 32'h0, 1'b0);
      apb(1'b0, RTC_WELL_STATUS_OFF, 32'h0, 32'h0000A500, 1'b0);
      strap_board_model_i.pulse(5);
      wait_clk(3);
      #1;
      check("test_mode", test_mode, TM_NONE);
      wait_clk(PG_STABLE_CLKS);
      for (int k = 0; k < 8; k++) begin
         strap_board_model_i.pulse(counts[k]);
         if (counts[k] < 9 || counts[k] > 42) tm = (counts[k] >= 4 && counts[k] <= 8) ? 3'(counts[k] - 3) : TM_NONE;
         wait_clk(3);
         #1;
         check("test_mode", test_mode, tm);
         wait_clk(1);
      end
      $display("test test_mode done");
      apb(1'b0, RTC_WELL_STATUS_OFF, 32'h0, 32'h00000004, 1'b0);
      apb(1'b1, RTC_WELL_STATUS_OFF, 32'h00000004, 32'h0, 1'b0);
      apb(1'b0, RTC_WELL_STATUS_OFF, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 8'hF0, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'hF0, 32'hFFFFFFFF, 32'h0, 1'b1);
      $display("test registers done");
      summarize();
   end
endmodule : tb_strap_and_test_mode_capture
